// file: cprc_regs.svh
// Constants for the channel protection and retry controller.
// Assumes a 25 MHz core clock; times are kept in their own units.
`ifndef CPRC_REGS_SVH
`define CPRC_REGS_SVH

`define CPRC_NCH 8
`define CPRC_NPAIR 4
`define CPRC_NPWM 2
`define CPRC_CLK_MHZ 25

// Mode change delay, longest figure, microseconds
`define CPRC_MODE_DLY_US 100
`define CPRC_MODE_DLY_CYC (`CPRC_MODE_DLY_US * `CPRC_CLK_MHZ)
`define CPRC_MODE_CNT_W 12

// Retry enable expiry, milliseconds
`define CPRC_BIM_EXPIRE_MS 40
`define CPRC_BIM_EXPIRE_CYC (`CPRC_BIM_EXPIRE_MS * 1000 * `CPRC_CLK_MHZ)
// Default retry time, microseconds
`define CPRC_RETRY_US 1000
`define CPRC_RETRY_CYC (`CPRC_RETRY_US * `CPRC_CLK_MHZ)
`define CPRC_TMR_W 21

// Status words
`define CPRC_LH_STATUS 16'h8680
`define CPRC_DIAG_SLEEP 16'h0000
`define CPRC_DIAG_PAD 8'h00

// Base oscillator trim
`define CPRC_TRIM_RSV 4'h0
`define CPRC_TRIM_NOM 4'h8
`define CPRC_BASE_DIV 9'h0F4
`define CPRC_TRIM_STEP 9'h00C
`define CPRC_BASE_W 9

// PWM frequency codes and counter
`define CPRC_FREQ_1024 2'h0
`define CPRC_FREQ_512 2'h1
`define CPRC_FREQ_256 2'h2
`define CPRC_FREQ_FULL 2'h3
`define CPRC_PWM_CNT_W 10

`endif

// file: cprc_pkg.sv
// Types shared by the channel protection and retry controller.
// Assumes cprc_regs.svh is compiled alongside.
package cprc_pkg;
  typedef enum logic [1:0] {
    CPRC_ACTIVE,
    CPRC_LIMP,
    CPRC_SLEEP
  } cprc_mode_t;
endpackage

// file: cprc_retry_timer.sv
// Per-channel inrush retry and retry-enable expiry timers.
// Assumes on_cmd and enable are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "cprc_regs.svh"

module cprc_retry_timer
  import cprc_pkg::*;
#(
  parameter logic [`CPRC_TMR_W-1:0] RETRY_CYC = `CPRC_TMR_W'(`CPRC_RETRY_CYC),
  parameter logic [`CPRC_TMR_W-1:0] EXPIRE_CYC = `CPRC_TMR_W'(`CPRC_BIM_EXPIRE_CYC)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Channel state
  input wire logic on_cmd,
  input wire logic enable,
  // Timer events
  output logic retry_tick,
  output logic expire
);
  logic [`CPRC_TMR_W-1:0] retry_cnt_r;
  logic [`CPRC_TMR_W-1:0] exp_cnt_r;

  // Retry period counted from switch-on
  always_ff @(posedge clk)
  begin
    if (!nrst || !on_cmd || !enable)
    begin
      retry_cnt_r <= '0;
      retry_tick <= 1'b0;
    end
    else if (retry_cnt_r == RETRY_CYC - `CPRC_TMR_W'(1))
    begin
      retry_cnt_r <= '0;
      retry_tick <= 1'b1;
    end
    else
    begin
      retry_cnt_r <= retry_cnt_r + `CPRC_TMR_W'(1);
      retry_tick <= 1'b0;
    end
  end

  // Expiry of the enable bit
  always_ff @(posedge clk)
  begin
    if (!nrst || !enable)
    begin
      exp_cnt_r <= '0;
      expire <= 1'b0;
    end
    else if (exp_cnt_r == EXPIRE_CYC - `CPRC_TMR_W'(1))
    begin
      exp_cnt_r <= exp_cnt_r;
      expire <= 1'b1;
    end
    else
    begin
      exp_cnt_r <= exp_cnt_r + `CPRC_TMR_W'(1);
      expire <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: cprc_pwm_gen.sv
// One PWM generator stepped by the shared base tick.
// Assumes base_tick is a one-cycle pulse on clk.
`timescale 1ns/1ns
`default_nettype none
`include "cprc_regs.svh"

module cprc_pwm_gen
  import cprc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Timing and settings
  input wire logic base_tick,
  input wire logic [7:0] duty,
  input wire logic [1:0] freq,
  // Output
  output logic pwm_out
);
  logic [`CPRC_PWM_CNT_W-1:0] cnt_r;
  logic [7:0] duty_r;
  logic [7:0] phase;
  logic period_end;

  always_comb
  begin
    phase = cnt_r[9:2];
    period_end = (cnt_r == 10'h3FF);
    unique case (freq)
      `CPRC_FREQ_1024:
      begin
        phase = cnt_r[9:2];
        period_end = (cnt_r == 10'h3FF);
      end
      `CPRC_FREQ_512:
      begin
        phase = cnt_r[8:1];
        period_end = (cnt_r[8:0] == 9'h1FF);
      end
      `CPRC_FREQ_256, `CPRC_FREQ_FULL:
      begin
        phase = cnt_r[7:0];
        period_end = (cnt_r[7:0] == 8'hFF);
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt_r <= '0;
    else if (base_tick)
      cnt_r <= cnt_r + `CPRC_PWM_CNT_W'(1);
  end

  // New duty taken at period end only
  always_ff @(posedge clk)
  begin
    if (!nrst)
      duty_r <= 8'h00;
    else if (base_tick && period_end)
      duty_r <= duty;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      pwm_out <= 1'b0;
    else
      pwm_out <= (freq == `CPRC_FREQ_FULL) || (phase < duty_r);
  end
endmodule
`default_nettype wire

// file: cprc_top.sv
// Channel protection, pairing, inrush retry, PWM base and mode control.
// Assumes host writes arrive as clk-synchronous levels and pulses;
// pins and analog detector outputs are asynchronous.
//
// Functional notes
// - Pair bits 0..3 join channels 0/2, 1/3, 4/6, 5/7 when set.
// - In a joined pair, a fault on one channel also shuts the partner off.
// - Pairing affects only fault reaction; each channel is switched individually.
// - Without retry, an overload latch-off holds until the host clears it.
// - With retry enabled, a latched channel restarts after the retry time.
// - The retry counter starts when the channel is switched on.
// - Any switch-off, from any source, clears the channel's retry enable.
// - With retry enabled the error flag may set, but no permanent latch-off.
// - A timer clears the retry enable 40 ms after it was set.
// - Retry mode is enabled per channel by its own bit.
// - Inverse current keeps channel state; error only when on and overheated.
// - Two independent PWM generators, each with own duty, frequency, mapping.
// - Both generators share one base frequency trimmed by a 4-bit field.
// - Idle pin low from active with a direct input high enters limp home within 100 us; status 868x.
// - Idle pin low from active with both direct inputs low enters sleep within 100 us; diagnosis reads 0000.
// - Trim code 0000 reserved, 1000 nominal, lower slower, higher faster.
`timescale 1ns/1ns
`default_nettype none
`include "cprc_regs.svh"

module cprc_top
  import cprc_pkg::*;
#(
  parameter logic [`CPRC_TMR_W-1:0] RETRY_CYC = `CPRC_TMR_W'(`CPRC_RETRY_CYC),
  parameter logic [`CPRC_TMR_W-1:0] EXPIRE_CYC = `CPRC_TMR_W'(`CPRC_BIM_EXPIRE_CYC)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins
  input wire logic idle_pin,
  input wire logic direct_input_0,
  input wire logic direct_input_1,
  // Host switch commands and input mapping
  input wire logic [7:0] spi_out_on,
  input wire logic [7:0] in0_map,
  input wire logic [7:0] in1_map,
  // Host protection settings
  input wire logic [3:0] pair_sync_bits,
  input wire logic [7:0] overload_latch_clear,
  input wire logic inrush_retry_mode_wr,
  input wire logic [7:0] inrush_retry_mode_data,
  // Host PWM settings
  input wire logic [3:0] pwm_base_trim,
  input wire logic [7:0] pwm0_duty,
  input wire logic [1:0] pwm0_freq,
  input wire logic [7:0] pwm0_map,
  input wire logic [7:0] pwm1_duty,
  input wire logic [1:0] pwm1_freq,
  input wire logic [7:0] pwm1_map,
  // Power stage detectors
  input wire logic [7:0] overload_det,
  input wire logic [7:0] overtemp_det,
  input wire logic [7:0] inverse_det,
  // Channel drive and status
  output logic [7:0] ch_gate,
  output logic [7:0] overload_latched,
  output logic [7:0] channel_error_flag,
  output logic [7:0] inrush_retry_enable,
  output logic [1:0] mode_state,
  output logic [15:0] input_status_report,
  output logic [15:0] std_diag_word
);
  // Two-stage synchronisers for all asynchronous inputs
  logic [26:0] sync1_r;
  logic [26:0] sync2_r;
  logic idle_s;
  logic in0_s;
  logic in1_s;
  logic [7:0] ovl_s;
  logic [7:0] ot_s;
  logic [7:0] inv_s;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {idle_pin, direct_input_1, direct_input_0,
                  overload_det, overtemp_det, inverse_det};
      sync2_r <= sync1_r;
    end
  end

  assign {idle_s, in1_s, in0_s, ovl_s, ot_s, inv_s} = sync2_r;

  // Mode control
  cprc_mode_t mode_r;
  cprc_mode_t mode_nxt;
  logic [`CPRC_MODE_CNT_W-1:0] mode_cnt_r;
  logic mode_req;

  always_comb
  begin
    mode_nxt = mode_r;
    mode_req = 1'b0;
    unique case (mode_r)
      CPRC_ACTIVE:
      begin
        mode_req = !idle_s;
        if (in0_s || in1_s)
          mode_nxt = CPRC_LIMP;
        else
          mode_nxt = CPRC_SLEEP;
      end
      CPRC_LIMP, CPRC_SLEEP:
      begin
        mode_req = idle_s;
        mode_nxt = CPRC_ACTIVE;
      end
      default:
      begin
        mode_req = 1'b1;
        mode_nxt = CPRC_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mode_r <= CPRC_ACTIVE;
      mode_cnt_r <= '0;
    end
    else if (!mode_req)
      mode_cnt_r <= '0;
    else if (mode_cnt_r == `CPRC_MODE_CNT_W'(`CPRC_MODE_DLY_CYC - 1))
    begin
      mode_r <= mode_nxt;
      mode_cnt_r <= '0;
    end
    else
      mode_cnt_r <= mode_cnt_r + `CPRC_MODE_CNT_W'(1);
  end

  logic [`CPRC_BASE_W-1:0] base_div;
  logic [`CPRC_BASE_W-1:0] base_cnt_r;
  logic base_tick_r;

  always_comb
  begin
    if (pwm_base_trim == `CPRC_TRIM_RSV)
      base_div = `CPRC_BASE_DIV;
    else if (pwm_base_trim < `CPRC_TRIM_NOM)
      base_div = `CPRC_BASE_DIV + `CPRC_TRIM_STEP *
                 `CPRC_BASE_W'(`CPRC_TRIM_NOM - pwm_base_trim);
    else
      base_div = `CPRC_BASE_DIV - `CPRC_TRIM_STEP *
                 `CPRC_BASE_W'(pwm_base_trim - `CPRC_TRIM_NOM);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      base_cnt_r <= '0;
      base_tick_r <= 1'b0;
    end
    else if (base_cnt_r >= base_div - `CPRC_BASE_W'(1))
    begin
      base_cnt_r <= '0;
      base_tick_r <= 1'b1;
    end
    else
    begin
      base_cnt_r <= base_cnt_r + `CPRC_BASE_W'(1);
      base_tick_r <= 1'b0;
    end
  end

  logic [1:0] pwm_out;
  logic [7:0] pwm_duty [2];
  logic [1:0] pwm_freq [2];
  assign pwm_duty[0] = pwm0_duty;
  assign pwm_duty[1] = pwm1_duty;
  assign pwm_freq[0] = pwm0_freq;
  assign pwm_freq[1] = pwm1_freq;

  genvar g;
  generate
    for (g = 0; g < `CPRC_NPWM; g++)
    begin : gen_pwm
      cprc_pwm_gen u_pwm (
        .clk(clk),
        .nrst(nrst),
        .base_tick(base_tick_r),
        .duty(pwm_duty[g]),
        .freq(pwm_freq[g]),
        .pwm_out(pwm_out[g])
      );
    end
  endgenerate

  // Switch commands from every source
  logic [7:0] cmd_on;
  logic [7:0] cmd_on_r;
  logic [7:0] fault;
  logic [7:0] retry_tick;
  logic [7:0] expire;

  always_comb
  begin
    unique case (mode_r)
      CPRC_ACTIVE:
        cmd_on = spi_out_on | ({8{in0_s}} & in0_map) | ({8{in1_s}} & in1_map) |
                 ({8{pwm_out[0]}} & pwm0_map) | ({8{pwm_out[1]}} & pwm1_map);
      CPRC_LIMP:
        cmd_on = ({8{in0_s}} & in0_map) | ({8{in1_s}} & in1_map);
      default:
        cmd_on = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cmd_on_r <= 8'h00;
    else
      cmd_on_r <= cmd_on;
  end

  generate
    for (g = 0; g < `CPRC_NCH; g++)
    begin : gen_ch
      localparam int PARTNER = g ^ 2;
      localparam int PAIR = ((g >> 2) << 1) | (g & 1);

      assign fault[g] = ch_gate[g] && !inv_s[g] && (ovl_s[g] || ot_s[g]);

      cprc_retry_timer #(
        .RETRY_CYC(RETRY_CYC),
        .EXPIRE_CYC(EXPIRE_CYC)
      ) u_tmr (
        .clk(clk),
        .nrst(nrst),
        .on_cmd(cmd_on[g]),
        .enable(inrush_retry_enable[g]),
        .retry_tick(retry_tick[g]),
        .expire(expire[g])
      );

      // Latched overload state; set wins over clear
      always_ff @(posedge clk)
      begin
        if (!nrst)
          overload_latched[g] <= 1'b0;
        else if (fault[g] || (pair_sync_bits[PAIR] && fault[PARTNER]))
          overload_latched[g] <= 1'b1;
        else if (overload_latch_clear[g])
          overload_latched[g] <= 1'b0;
        else if (inrush_retry_enable[g] && retry_tick[g])
          overload_latched[g] <= 1'b0;
      end

      // Error flag; set wins over clear
      always_ff @(posedge clk)
      begin
        if (!nrst)
          channel_error_flag[g] <= 1'b0;
        // overheat while on under inverse current
        else if (fault[g] || (ch_gate[g] && inv_s[g] && ot_s[g]))
          channel_error_flag[g] <= 1'b1;
        else if (overload_latch_clear[g])
          channel_error_flag[g] <= 1'b0;
      end

      always_ff @(posedge clk)
      begin
        if (!nrst)
          inrush_retry_enable[g] <= 1'b0;
        else if (inrush_retry_mode_wr)
          inrush_retry_enable[g] <= inrush_retry_mode_data[g];
        else if (cmd_on_r[g] && !cmd_on[g])
          inrush_retry_enable[g] <= 1'b0;
        else if (expire[g])
          inrush_retry_enable[g] <= 1'b0;
      end

      // each channel follows its own command
      always_ff @(posedge clk)
      begin
        if (!nrst)
          ch_gate[g] <= 1'b0;
        else
          ch_gate[g] <= cmd_on[g] && !overload_latched[g] && !fault[g] &&
                        !(pair_sync_bits[PAIR] && fault[PARTNER]);
      end
    end
  endgenerate

  // Mode and status words
  always_ff @(posedge clk)
  begin
    if (!nrst)
      mode_state <= 2'(CPRC_ACTIVE);
    else
      mode_state <= 2'(mode_r);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      input_status_report <= `CPRC_DIAG_SLEEP;
    else if (mode_r == CPRC_LIMP)
      input_status_report <= `CPRC_LH_STATUS | {14'h0000, in1_s, in0_s};
    else
      input_status_report <= {`CPRC_DIAG_PAD, 6'h00, in1_s, in0_s};
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      std_diag_word <= `CPRC_DIAG_SLEEP;
    else if (mode_r == CPRC_SLEEP)
      std_diag_word <= `CPRC_DIAG_SLEEP;
    else
      std_diag_word <= {`CPRC_DIAG_PAD, channel_error_flag};
  end
endmodule
`default_nettype wire

// file: cprc_top_asserts.sv
// Checker for the channel protection block, bound to its top module.
// Assumes it sees only the top module's ports; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none

module cprc_top_asserts
#(
  parameter logic [20:0] RETRY_CYC = 21'h0061A8,
  parameter logic [20:0] EXPIRE_CYC = 21'h0F4240
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins and host settings
  input wire logic idle_pin,
  input wire logic [3:0] pair_sync_bits,
  input wire logic [7:0] overload_latch_clear,
  input wire logic inrush_retry_mode_wr,
  // Outputs
  input wire logic [7:0] ch_gate,
  input wire logic [7:0] overload_latched,
  input wire logic [7:0] inrush_retry_enable,
  input wire logic [1:0] mode_state,
  input wire logic [15:0] input_status_report,
  input wire logic [15:0] std_diag_word
);
  logic [20:0] en_cnt_r;
  logic [20:0] lat_cnt_r;
  logic [12:0] idle_cnt_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Age of the retry enable of channel 6
  always_ff @(posedge clk)
    if (!nrst || !inrush_retry_enable[6] || inrush_retry_mode_wr)
      en_cnt_r <= 21'h000000;
    else
      en_cnt_r <= en_cnt_r + 21'h000001;

  // Time channel 4 spends latched with retry on
  always_ff @(posedge clk)
    if (!nrst || !(overload_latched[4] && inrush_retry_enable[4]))
      lat_cnt_r <= 21'h000000;
    else
      lat_cnt_r <= lat_cnt_r + 21'h000001;

  // Time the idle pin has been low
  always_ff @(posedge clk)
    if (!nrst || idle_pin)
      idle_cnt_r <= 13'h0000;
    else
      idle_cnt_r <= idle_cnt_r + 13'h0001;

  a_pair_shutoff: assert property (pair_sync_bits[0] && $rose(overload_latched[0])
    |-> overload_latched[2]) else $error("partner channel not latched");
  a_latch_gate_off: assert property (
    (overload_latched & ch_gate) == 8'h00) else $error("latched channel driven");
  a_latch_holds: assert property ($fell(overload_latched[0]) |->
    $past(overload_latch_clear[0]) || $past(inrush_retry_enable[0]))
    else $error("latch released without cause");
  a_retry_restart: assert property (
    lat_cnt_r <= RETRY_CYC) else $error("retry restart late");
  a_retry_expire: assert property (
    en_cnt_r <= EXPIRE_CYC + 21'h000002) else $error("retry enable not expired");
  a_mode_delay: assert property ($past(mode_state) == 2'h0 && mode_state != 2'h0
    |-> idle_cnt_r inside {[13'h09C4:13'h09CE]}) else $error("mode change timing");
  a_limp_status: assert property (mode_state == 2'h1 && $past(mode_state) == 2'h1
    |-> input_status_report[15:2] == 14'h21A0) else $error("limp status word");
  a_sleep_quiet: assert property (mode_state == 2'h2 && $past(mode_state) == 2'h2
    |-> ch_gate == 8'h00 && std_diag_word == 16'h0000) else $error("sleep not quiet");

  c_pair: cover property (pair_sync_bits[0] && $rose(overload_latched[0]));
  c_limp: cover property ($rose(mode_state == 2'h1));
  c_sleep: cover property ($rose(mode_state == 2'h2));
endmodule

bind cprc_top cprc_top_asserts #(.RETRY_CYC(RETRY_CYC), .EXPIRE_CYC(EXPIRE_CYC))
  i_cprc_top_asserts (.*);

`default_nettype wire

// file: cprc_host_model.sv
// Host side model driving the block's control and setting inputs.
// Assumes clk is the block clock; settings change after its falling edge.
`timescale 1ns/1ns
`default_nettype none

module cprc_host_model
(
  // Clock
  input wire logic clk,
  // Switch and protection settings
  output logic [7:0] spi_out_on,
  output logic [7:0] in0_map,
  output logic [7:0] in1_map,
  output logic [3:0] pair_sync_bits,
  output logic [7:0] overload_latch_clear,
  output logic inrush_retry_mode_wr,
  output logic [7:0] inrush_retry_mode_data,
  // PWM settings
  output logic [3:0] pwm_base_trim,
  output logic [7:0] pwm0_duty,
  output logic [1:0] pwm0_freq,
  output logic [7:0] pwm0_map,
  output logic [7:0] pwm1_duty,
  output logic [1:0] pwm1_freq,
  output logic [7:0] pwm1_map
);
  initial
  begin
    {spi_out_on, in0_map, in1_map, pair_sync_bits} = 28'h0000000;
    {overload_latch_clear, inrush_retry_mode_wr, inrush_retry_mode_data} = 17'h00000;
    {pwm0_duty, pwm0_freq, pwm0_map, pwm1_duty, pwm1_freq, pwm1_map} = 36'h000000000;
    pwm_base_trim = 4'h8;
  end

  task automatic set_on(input logic [7:0] v);
    @(negedge clk);
    spi_out_on = v;
  endtask

  task automatic clear(input logic [7:0] m);
    @(negedge clk);
    overload_latch_clear = m;
    @(negedge clk);
    overload_latch_clear = 8'h00;
  endtask

  task automatic set_retry(input logic [7:0] v);
    @(negedge clk);
    inrush_retry_mode_data = v;
    inrush_retry_mode_wr = 1'b1;
    @(negedge clk);
    inrush_retry_mode_wr = 1'b0;
  endtask

  task automatic cfg(input logic [3:0] p, input logic [7:0] m0, input logic [7:0] m1);
    @(negedge clk);
    pair_sync_bits = p;
    in0_map = m0;
    in1_map = m1;
  endtask

  // Generator maps, frequencies, duties and shared trim
  task automatic pwm(input logic [7:0] m0, input logic [7:0] m1, input logic [1:0] f0,
                     input logic [1:0] f1, input logic [7:0] d0, input logic [7:0] d1,
                     input logic [3:0] t);
    @(negedge clk);
    pwm0_map = m0;
    pwm1_map = m1;
    pwm0_freq = f0;
    pwm1_freq = f1;
    pwm0_duty = d0;
    pwm1_duty = d1;
    pwm_base_trim = t;
  endtask
endmodule

`default_nettype wire

// file: cprc_tb.sv
// Self-checking bench for the channel protection block.
// Assumes short retry and expiry counts; pins and detectors driven here.
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clk;
  logic nrst;
  logic idle_pin;
  logic direct_input_0;
  logic direct_input_1;
  logic [7:0] overload_det, overtemp_det, inverse_det;
  logic [7:0] spi_out_on, in0_map, in1_map, overload_latch_clear, inrush_retry_mode_data;
  logic [7:0] pwm0_duty, pwm0_map, pwm1_duty, pwm1_map;
  logic [3:0] pair_sync_bits, pwm_base_trim;
  logic [1:0] pwm0_freq, pwm1_freq, mode_state;
  logic inrush_retry_mode_wr;
  logic [7:0] ch_gate, overload_latched, channel_error_flag, inrush_retry_enable;
  logic [15:0] input_status_report, std_diag_word;
  int err_count;
  int total_checks;
  int k;

  cprc_host_model i_host (.*);
  cprc_top #(.RETRY_CYC(21'h000014), .EXPIRE_CYC(21'h0000C8)) i_cprc_top (.*);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 2700 && mode_state !== m; i++)
      @(negedge clk);
    chk(16'(mode_state), 16'(m));
    if (mode_state !== m)
      print_verdict();
  endtask

  initial
  begin
    err_count = 0;
    total_checks = 0;
    nrst = 1'b0;
    idle_pin = 1'b1;
    direct_input_0 = 1'b0;
    direct_input_1 = 1'b0;
    overload_det = 8'h00;
    overtemp_det = 8'h00;
    inverse_det = 8'h00;
    cyc(3);
    nrst = 1'b1;
    i_host.cfg(4'h1, 8'h00, 8'h00);
    i_host.set_on(8'h0F);
    cyc(4);
    chk(16'(ch_gate), 16'h000F);
    overload_det = 8'h01;
    cyc(6);
    chk(16'(overload_latched), 16'h0005);
    chk(16'(channel_error_flag), 16'h0001);
    overload_det = 8'h02;
    cyc(6);
    chk(16'(ch_gate), 16'h0008);
    overload_det = 8'h00;
    cyc(20);
    chk(16'(overload_latched), 16'h0007);
    i_host.clear(8'h07);
    cyc(4);
    chk(16'(ch_gate), 16'h000F);
    i_host.cfg(4'h3, 8'h04, 8'h08);
    overtemp_det = 8'h08;
    cyc(6);
    chk(16'(overload_latched), 16'h000A);
    overtemp_det = 8'h00;
    i_host.clear(8'h0A);
    inverse_det = 8'h01;
    overload_det = 8'h01;
    overtemp_det = 8'h01;
    cyc(6);
    chk(16'(ch_gate), 16'h000F);
    chk(std_diag_word, 16'h0001);
    inverse_det = 8'h00;
    overload_det = 8'h00;
    overtemp_det = 8'h00;
    i_host.set_on(8'h30);
    i_host.set_retry(8'h10);
    overload_det = 8'h30;
    cyc(6);
    chk(16'(overload_latched), 16'h0030);
    overload_det = 8'h00;
    cyc(24);
    chk(16'(ch_gate), 16'h0010);
    chk(16'(overload_latched), 16'h0020);
    i_host.clear(8'h20);
    i_host.set_on(8'h70);
    i_host.set_retry(8'h70);
    cyc(10);
    i_host.set_on(8'h40);
    cyc(4);
    chk(16'(inrush_retry_enable), 16'h0040);
    cyc(200);
    chk(16'(inrush_retry_enable), 16'h0000);
    i_host.set_on(8'h00);
    i_host.pwm(8'h80, 8'h01, 2'h2, 2'h3, 8'h10, 8'h40, 4'hF);
    for (k = 0; k < 45000 && ch_gate[7] !== 1'b1; k++)
      @(negedge clk);
    chk(16'(ch_gate), 16'h0081);
    for (k = 0; k < 3000 && ch_gate[7] === 1'b1; k++)
      @(negedge clk);
    // Sixteen ticks of a 160-clock base at trim 1111
    chk(16'(k), 16'h0A00);
    for (k = 0; k < 4; k++)
    begin
      direct_input_0 = k[0];
      direct_input_1 = k[1];
      cyc(4);
      idle_pin = 1'b0;
      wait_mode(k == 0 ? 2'h2 : 2'h1);
      cyc(2);
      if (k == 0)
        chk(std_diag_word, 16'h0000);
      else
        chk(input_status_report, 16'h8680 | 16'(k));
      chk(16'(ch_gate), 16'(k * 4));
      idle_pin = 1'b1;
      wait_mode(2'h0);
    end
    print_verdict();
  end
endmodule

`default_nettype wire
